// ==== slc_stack_limit_checker.sv ====
// Stack pointer sequencer with limit and floor checking.
`timescale 1ns/1ps
`default_nettype none
module slc_stack_limit_checker
    import slc_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    // Stack requests.
    input wire logic req_valid,
    input wire logic [2:0] req_op,
    input wire logic [15:0] req_data,
    input wire logic [PC_W-1:0] req_pc,
    input wire logic [7:0] status_low_byte,
    output logic req_ready,
    // Pointer loads.
    input wire logic sp_load,
    input wire logic limit_load,
    input wire logic [15:0] load_data,
    // Memory access.
    output logic [15:0] effective_addr,
    output logic [15:0] mem_wdata,
    output logic mem_we,
    output logic mem_re,
    // Status.
    output logic [15:0] stack_pointer_reg,
    output logic [15:0] stack_limit_reg,
    output logic stack_err,
    output logic stack_ovf,
    output logic stack_unf
);

    // ****************************************
    // State
    // ****************************************
    slc_regs_t q;
    slc_regs_t d;
    slc_chk_if chk ();
    logic take;
    logic access;

    slc_bound_cmp u_cmp (
        .clk(clk),
        .rst_n(rst_n),
        .chk(chk)
    );

    assign req_ready = (q.st == ST_IDLE);
    assign take = req_valid && req_ready;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        d.we = 1'b0;
        d.re = 1'b0;
        d.err = 1'b0;
        d.ovf = 1'b0;
        d.unf = 1'b0;
        access = 1'b0;
        chk.ea = q.sp;
        chk.lim = q.lim;
        case (q.st)
            ST_IDLE: begin
                if (take) begin
                    access = 1'b1;
                    case (slc_op_t'(req_op))
                        OP_PUSH: begin
                            d.we = 1'b1;
                            d.wdata = req_data;
                            d.sp = q.sp + WORD_STEP;
                        end
                        OP_CALL: begin
                            d.we = 1'b1;
                            d.wdata = req_pc[15:0];
                            d.sp = q.sp + WORD_STEP;
                            d.upper = {8'h00, 1'b0, req_pc[22:16]};
                            d.st = ST_UPPER;
                        end
                        OP_EXC: begin
                            d.we = 1'b1;
                            d.wdata = req_pc[15:0];
                            d.sp = q.sp + WORD_STEP;
                            d.upper = {status_low_byte, req_pc[23:16]};
                            d.st = ST_UPPER;
                        end
                        OP_POP: begin
                            d.re = 1'b1;
                            chk.ea = q.sp - WORD_STEP;
                            d.sp = q.sp - WORD_STEP;
                        end
                        OP_READ: begin
                            // Uses the limit as registered; a load in the
                            // previous cycle is already visible here.
                            d.re = 1'b1;
                            chk.ea = q.sp + req_data;
                        end
                        OP_WRITE: begin
                            d.we = 1'b1;
                            d.wdata = req_data;
                            chk.ea = q.sp + req_data;
                        end
                        default: begin
                            access = 1'b0;
                        end
                    endcase
                end else begin
                    if (sp_load) begin
                        d.sp = {load_data[15:1], 1'b0};
                    end
                    if (limit_load) begin
                        d.lim = {load_data[15:1], 1'b0};
                    end
                end
            end
            ST_UPPER: begin
                access = 1'b1;
                d.we = 1'b1;
                d.wdata = q.upper;
                d.sp = q.sp + WORD_STEP;
                d.st = ST_IDLE;
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        if (access) begin
            d.addr = chk.ea;
            d.ovf = chk.over;
            d.unf = chk.under;
            d.err = chk.over || chk.under;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.st <= ST_IDLE;
            q.sp <= SP_RESET;
            q.lim <= LIMIT_RESET;
            q.upper <= ZERO_WORD;
            q.addr <= ZERO_WORD;
            q.wdata <= ZERO_WORD;
            q.we <= 1'b0;
            q.re <= 1'b0;
            q.err <= 1'b0;
            q.ovf <= 1'b0;
            q.unf <= 1'b0;
        end else if (en) begin
            q <= d;
        end
    end

    assign effective_addr = q.addr;
    assign mem_wdata = q.wdata;
    assign mem_we = q.we;
    assign mem_re = q.re;
    assign stack_pointer_reg = q.sp;
    assign stack_limit_reg = q.lim;
    assign stack_err = q.err;
    assign stack_ovf = q.ovf;
    assign stack_unf = q.unf;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_push;
        en && take && req_op == OP_PUSH;
    endsequence

    sequence s_call;
        en && take && req_op == OP_CALL ##1 en;
    endsequence

    sequence s_exc;
        en && take && req_op == OP_EXC ##1 en;
    endsequence

    a_push_incr: assert property (@(posedge clk) disable iff (!rst_n)
        s_push |=> mem_we && effective_addr == $past(q.sp)
            && stack_pointer_reg == $past(q.sp) + WORD_STEP)
        else $error("Push did not use then increment the pointer.");

    a_pop_decr: assert property (@(posedge clk) disable iff (!rst_n)
        (en && take && req_op == OP_POP) |=> mem_re
            && stack_pointer_reg == $past(q.sp) - WORD_STEP
            && effective_addr == stack_pointer_reg)
        else $error("Pop did not decrement before use.");

    a_next_free: assert property (@(posedge clk) disable iff (!rst_n)
        s_push |=> stack_pointer_reg == effective_addr + WORD_STEP)
        else $error("Pointer does not name the next free word.");

    a_call_msb: assert property (@(posedge clk) disable iff (!rst_n)
        s_call |=> mem_we && mem_wdata[15:7] == 9'h000
            && mem_wdata[6:0] == $past(req_pc[22:16], 2))
        else $error("Call upper word MSb not cleared.");

    a_exc_status: assert property (@(posedge clk) disable iff (!rst_n)
        s_exc |=> mem_we && mem_wdata[15:8] == $past(status_low_byte, 2)
            && mem_wdata[7:0] == $past(req_pc[23:16], 2))
        else $error("Exception upper word lacks status byte.");

    a_limit_even: assert property (@(posedge clk) disable iff (!rst_n)
        stack_limit_reg[0] == 1'b0)
        else $error("Limit bit zero set.");

    a_limit_equal: assert property (@(posedge clk) disable iff (!rst_n)
        s_push and (q.sp == q.lim && q.sp >= STACK_FLOOR) |=> !stack_err)
        else $error("Push at limit raised an error.");

    a_limit_over: assert property (@(posedge clk) disable iff (!rst_n)
        s_push and (q.sp == q.lim + WORD_STEP && q.lim != LIMIT_RESET) |=> stack_err)
        else $error("Push past limit not trapped.");

    a_floor_pop: assert property (@(posedge clk) disable iff (!rst_n)
        (en && take && req_op == OP_POP && q.sp < STACK_FLOOR + WORD_STEP) |=> stack_unf
            && stack_err)
        else $error("Pop below floor not trapped.");

    a_err_single: assert property (@(posedge clk) disable iff (!rst_n)
        stack_err |-> (mem_we || mem_re) && (stack_ovf || stack_unf))
        else $error("Error without its access.");

endmodule
`default_nettype wire

// ==== slc_pkg.sv ====
// Constants and types shared by the stack limit checker.
// Behaviour
// - Stack pointer names next free word, grows upward.
// - Push uses then increments; pop decrements then uses.
// - Call pushes upper PC word with MSb zero.
// - Exception push joins status low byte to PC.
// - Limit register undefined after reset; software loads. Reset here loads LIMIT_RESET, 16'hFFFE.
// - Limit bit zero always reads zero.
// - Every stack-pointer address compared with limit.
// - Push at limit passes; next push traps.
// - Address below floor raises underflow trap.
package slc_pkg;

    // ****************************************
    // Constants
    // ****************************************
    localparam int unsigned DATA_W = 16;
    localparam int unsigned PC_W = 24;
    localparam logic [15:0] STACK_FLOOR = 16'h0800;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] SP_RESET = 16'h0800;
    localparam logic [15:0] LIMIT_RESET = 16'hFFFE;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        OP_PUSH = 3'b000,
        OP_POP = 3'b001,
        OP_CALL = 3'b010,
        OP_EXC = 3'b011,
        OP_READ = 3'b100,
        OP_WRITE = 3'b101
    } slc_op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_UPPER = 1'b1
    } slc_state_t;

    typedef struct packed {
        slc_state_t st;
        logic [15:0] sp;
        logic [15:0] lim;
        logic [15:0] upper;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic we;
        logic re;
        logic err;
        logic ovf;
        logic unf;
    } slc_regs_t;

endpackage

// ==== slc_chk_if.sv ====
// Interface between the sequencer and the bounds comparator.
`timescale 1ns/1ps
`default_nettype none
interface slc_chk_if;
    logic [15:0] ea;
    logic [15:0] lim;
    logic over;
    logic under;
    modport seq (output ea, output lim, input over, input under);
    modport cmp (input ea, input lim, output over, output under);
endinterface
`default_nettype wire

// ==== slc_bound_cmp.sv ====
// Bounds comparator for stack effective addresses.
`timescale 1ns/1ps
`default_nettype none
module slc_bound_cmp
    import slc_pkg::*;
(
    // Clock and reset for checking.
    input wire logic clk,
    input wire logic rst_n,
    // Address and limit.
    slc_chk_if.cmp chk
);

    // ****************************************
    // Comparison
    // ****************************************
    // Above the limit is overflow; below the floor is underflow.
    assign chk.over = (chk.ea > chk.lim);
    assign chk.under = (chk.ea < STACK_FLOOR);

    // ****************************************
    // Checks
    // ****************************************
    a_cmp_limit_eq: assert property (@(posedge clk) disable iff (!rst_n)
        (chk.ea == chk.lim) |-> !chk.over)
        else $error("Address equal to limit flagged as overflow.");

    a_cmp_floor: assert property (@(posedge clk) disable iff (!rst_n)
        (chk.ea < STACK_FLOOR) |-> chk.under)
        else $error("Address below floor not flagged.");

endmodule
`default_nettype wire

// ==== slc_trap_model.sv ====
// Trap logic model that watches stack accesses and counts stack errors.
`timescale 1ns/1ps
`default_nettype none
module slc_trap_model
    import slc_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    // Memory access and error.
    input wire logic mem_we,
    input wire logic mem_re,
    input wire logic stack_err,
    input wire logic [15:0] effective_addr,
    input wire logic [15:0] mem_wdata,
    // Observations.
    output logic [7:0] trap_count,
    output logic [15:0] last_wdata,
    output logic [15:0] trap_addr
);
    // ****************************************
    // Trap counting
    // ****************************************
    // Each error is one trap, taken only together with its access.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trap_count <= 8'h00;
            last_wdata <= 16'h0000;
            trap_addr <= 16'h0000;
        end else if (en) begin
            if (stack_err && (mem_we || mem_re)) begin
                trap_count <= trap_count + 8'h01;
                trap_addr <= effective_addr;
            end
            if (mem_we) begin
                last_wdata <= mem_wdata;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking testbench for the stack limit checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import slc_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b1;
    logic req_valid = 1'b0;
    logic sp_load = 1'b0;
    logic limit_load = 1'b0;
    logic [2:0] req_op = 3'h0;
    logic [15:0] req_data = 16'h0000;
    logic [15:0] load_data = 16'h0000;
    logic [PC_W-1:0] req_pc = 24'h00_0000;
    logic [7:0] status_low_byte = 8'h00;
    logic req_ready, mem_we, mem_re, stack_err, stack_ovf, stack_unf;
    logic [15:0] effective_addr, mem_wdata, stack_pointer_reg, stack_limit_reg, last_wdata;
    logic [7:0] trap_count;
    logic [15:0] trap_addr;
    int n_fail = 0;
    int samples_checked = 0;
    always #25 clk = ~clk;
    slc_stack_limit_checker i_dut (.clk(clk), .rst_n(rst_n), .en(en), .req_valid(req_valid),
        .req_op(req_op), .req_data(req_data), .req_pc(req_pc),
        .status_low_byte(status_low_byte), .req_ready(req_ready), .sp_load(sp_load),
        .limit_load(limit_load), .load_data(load_data), .effective_addr(effective_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
        .stack_pointer_reg(stack_pointer_reg), .stack_limit_reg(stack_limit_reg),
        .stack_err(stack_err), .stack_ovf(stack_ovf), .stack_unf(stack_unf));
    slc_trap_model i_cpu (.clk(clk), .rst_n(rst_n), .en(en), .mem_we(mem_we),
        .mem_re(mem_re), .stack_err(stack_err), .effective_addr(effective_addr),
        .mem_wdata(mem_wdata), .trap_count(trap_count), .last_wdata(last_wdata),
        .trap_addr(trap_addr));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic acc(input logic we, input logic re, input logic [15:0] a, input logic e);
        check("mem_we", mem_we, we);
        check("mem_re", mem_re, re);
        check("effective_addr", effective_addr, a);
        check("stack_err", stack_err, e);
    endtask
    task automatic load(input logic to_sp, input logic [15:0] v);
        @(negedge clk);
        sp_load = to_sp;
        limit_load = !to_sp;
        load_data = v;
        @(negedge clk);
        sp_load = 1'b0;
        limit_load = 1'b0;
    endtask
    task automatic issue(input logic [2:0] op, input logic [15:0] d, input logic [23:0] pc,
        input logic [7:0] slb);
        @(negedge clk);
        req_valid = 1'b1;
        req_op = op;
        req_data = d;
        req_pc = pc;
        status_low_byte = slb;
        @(negedge clk);
        req_valid = 1'b0;
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        check("sp", stack_pointer_reg, SP_RESET);
        check("ready", req_ready, 1'b1);
        check("err", stack_err, 1'b0);
    endtask
    task automatic t_push_limit;
        load(1'b0, 16'h0C01);
        check("limit", stack_limit_reg, 16'h0C00);
        load(1'b1, 16'h0800);
        load(1'b0, 16'h0802);
        issue(OP_PUSH, 16'hA1B2, 24'h00_0000, 8'h00);
        acc(1'b1, 1'b0, 16'h0800, 1'b0);
        check("wdata", mem_wdata, 16'hA1B2);
        check("sp", stack_pointer_reg, 16'h0802);
        issue(OP_PUSH, 16'hC3D4, 24'h00_0000, 8'h00);
        acc(1'b1, 1'b0, 16'h0802, 1'b0);
        issue(OP_PUSH, 16'hE5F6, 24'h00_0000, 8'h00);
        acc(1'b1, 1'b0, 16'h0804, 1'b1);
        check("ovf", stack_ovf, 1'b1);
        @(negedge clk);
        acc(1'b0, 1'b0, 16'h0804, 1'b0);
    endtask
    task automatic t_pop;
        load(1'b0, 16'hFFFE);
        // A spare cycle separates the limit write from the next stack read.
        issue(OP_POP, 16'h0000, 24'h00_0000, 8'h00);
        acc(1'b0, 1'b1, 16'h0804, 1'b0);
        check("sp", stack_pointer_reg, 16'h0804);
    endtask
    task automatic t_pc_push;
        load(1'b1, 16'h0900);
        issue(OP_CALL, 16'h0000, 24'hFF_1234, 8'h00);
        acc(1'b1, 1'b0, 16'h0900, 1'b0);
        check("wdata", mem_wdata, 16'h1234);
        check("ready", req_ready, 1'b0);
        @(negedge clk);
        acc(1'b1, 1'b0, 16'h0902, 1'b0);
        check("wdata", mem_wdata, 16'h007F);
        issue(OP_EXC, 16'h0000, 24'h81_5678, 8'hA5);
        check("wdata", mem_wdata, 16'h5678);
        @(negedge clk);
        acc(1'b1, 1'b0, 16'h0906, 1'b0);
        check("wdata", mem_wdata, 16'hA581);
        check("sp", stack_pointer_reg, 16'h0908);
    endtask
    task automatic t_under;
        load(1'b1, 16'h0800);
        issue(OP_POP, 16'h0000, 24'h00_0000, 8'h00);
        acc(1'b0, 1'b1, 16'h07FE, 1'b1);
        check("unf", stack_unf, 1'b1);
        load(1'b1, 16'h0A00);
        issue(OP_READ, 16'h0010, 24'h00_0000, 8'h00);
        acc(1'b0, 1'b1, 16'h0A10, 1'b0);
        check("sp", stack_pointer_reg, 16'h0A00);
        issue(OP_WRITE, 16'hF600, 24'h00_0000, 8'h00);
        acc(1'b1, 1'b0, 16'h0000, 1'b1);
        @(negedge clk);
        check("traps", trap_count, 8'h03);
        check("last write", last_wdata, 16'hF600);
        check("trap addr", trap_addr, 16'h0000);
    endtask
    task automatic t_hold;
        @(negedge clk);
        en = 1'b0;
        req_valid = 1'b1;
        req_op = OP_PUSH;
        req_data = 16'h1357;
        @(negedge clk);
        check("sp", stack_pointer_reg, 16'h0A00);
        check("mem_we", mem_we, 1'b0);
        en = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        en = 1'b0;
        acc(1'b1, 1'b0, 16'h0A00, 1'b0);
        check("wdata", mem_wdata, 16'h1357);
        @(negedge clk);
        acc(1'b1, 1'b0, 16'h0A00, 1'b0);
        check("sp", stack_pointer_reg, 16'h0A02);
        en = 1'b1;
        req_valid = 1'b1;
        req_op = 3'b110;
        sp_load = 1'b1;
        load_data = 16'h0C00;
        @(negedge clk);
        req_valid = 1'b0;
        sp_load = 1'b0;
        acc(1'b0, 1'b0, 16'h0A00, 1'b0);
        check("sp", stack_pointer_reg, 16'h0A02);
        check("traps", trap_count, 8'h03);
    endtask
    // ****************************************
    // Sequence and watchdog
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_reset();
        t_push_limit();
        t_pop();
        t_pc_push();
        t_under();
        t_hold();
        wrap_up();
    end
    initial begin
        #100000;
        n_fail++;
        wrap_up();
    end
endmodule
`default_nettype wire
